/* rtl/dri_top.sv */
// Two-instance converter register interface with an APB slave port.
//
// Design decision made here: the APB slave port.

// --------------------------------------------------------------------------
// Functional notes
// - Two identical instances, each decoded at its own base address.
// - Writing one to control bit 0 resets that instance only; zero does nothing.
// - Trigger disabled: holding value reaches output one clock after write.
// - Trigger enabled: only the selected timer trigger copies to output.
// - Each rising edge of the selected timer wave moves latest held value.
// - Select codes 0 to 5 choose timer wave; 6 and 7 never trigger.
// - Resolution bit zero selects 10-bit, one selects 8-bit operation.
// - In 8-bit mode holding writes are shifted left two, low bits zero.
// - Holding reads return the shifted value, upper bits zero.
// - Output register reads the converted sample, upper bits zero.
// - Ready flag reads zero after a holding write until transfer.
// - Ready flag reads one once a timer trigger transfers the latest held value.
// - Ready flag is zero at reset and while triggering is disabled.
// - Turning the trigger enable on sets the ready flag.
// - Writing one to enable-set bit 0 sets the interrupt mask bit.
// - Writing one to enable-clear bit 0 clears the interrupt mask bit.
// - Mask register bit 0 shows the mask, zero after reset.
// - Resolution sets transfer size: byte in 8-bit, half-word in 10-bit.
module dri_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] timer_wave_out,
  output logic [9:0] conv_code_0,
  output logic [9:0] conv_code_1,
  output logic [1:0] conv_irq,
  output logic [1:0] dma_halfword
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_is(input logic [31:0] addr,
                                  input logic [13:0] off);
    reg_is = (addr[13:0] == off);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // ----------------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------------
  logic [31:0] ch_base [dri_pkg::NUM_CH];
  logic [dri_pkg::NUM_CH-1:0] ch_hit;
  logic off_mapped;
  logic any_hit;
  logic setup_ph;
  logic wr_acc;
  logic sel_ch1;

  assign ch_base[0] = dri_pkg::BASE_CH0;
  assign ch_base[1] = dri_pkg::BASE_CH1;

  assign off_mapped = reg_is(paddr, dri_pkg::OFF_CONTROL) |
                      reg_is(paddr, dri_pkg::OFF_MODE) |
                      reg_is(paddr, dri_pkg::OFF_HOLDING) |
                      reg_is(paddr, dri_pkg::OFF_OUTPUT) |
                      reg_is(paddr, dri_pkg::OFF_STATUS) |
                      reg_is(paddr, dri_pkg::OFF_IRQ_SET) |
                      reg_is(paddr, dri_pkg::OFF_IRQ_CLR) |
                      reg_is(paddr, dri_pkg::OFF_IRQ_MASK);
  assign any_hit = (|ch_hit) & off_mapped;
  assign setup_ph = psel & ~penable;
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite & any_hit;
  assign sel_ch1 = ch_hit[1];

  // ----------------------------------------------------------------------
  // Timer trigger edge detection, shared by both instances
  // ----------------------------------------------------------------------
  logic [dri_pkg::NUM_TRG-1:0] trg_rise;
  logic [7:0] trg_rise_pad;

  // Padding to eight entries keeps the reserved codes inside the index range.
  assign trg_rise_pad = {2'b00, trg_rise};

  for (genvar t = 0; t < dri_pkg::NUM_TRG; t++) begin : g_trg
    dri_edge_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .wave_in(timer_wave_out[t]),
      .rise_pulse(trg_rise[t])
    );
  end

  // ----------------------------------------------------------------------
  // Per-instance register sets
  // ----------------------------------------------------------------------
  logic [dri_pkg::MODE_W-1:0] mode_r [dri_pkg::NUM_CH];
  logic [9:0] hold_r [dri_pkg::NUM_CH];
  logic [9:0] out_r [dri_pkg::NUM_CH];
  logic [dri_pkg::NUM_CH-1:0] ready_r;
  logic [dri_pkg::NUM_CH-1:0] mask_r;
  logic [dri_pkg::NUM_CH-1:0] copy_pend_r;
  logic [31:0] rd_val [dri_pkg::NUM_CH];

  for (genvar g = 0; g < dri_pkg::NUM_CH; g++) begin : g_ch
    logic wr_ch;
    logic soft_rst;
    logic wr_mode;
    logic wr_hold;
    logic irq_set;
    logic irq_clr;
    logic [31:0] mode_wide;
    logic [31:0] hold_wide;
    logic [dri_pkg::MODE_W-1:0] mode_nxt;
    logic [9:0] hold_nxt;
    logic [9:0] out_nxt;
    logic [2:0] trg_sel;
    logic trg_en;
    logic trg_fire;
    logic trg_turn_on;
    logic ready_nxt;
    logic mask_nxt;
    logic copy_pend_nxt;

    assign ch_hit[g] = (paddr[31:dri_pkg::WIN_LSB] ==
                        ch_base[g][31:dri_pkg::WIN_LSB]);
    assign wr_ch = wr_acc & ch_hit[g];

    assign soft_rst = wr_ch & reg_is(paddr, dri_pkg::OFF_CONTROL) &
                      pstrb[0] & pwdata[dri_pkg::SOFT_RESET_POS];
    assign wr_mode = wr_ch & reg_is(paddr, dri_pkg::OFF_MODE);
    assign wr_hold = wr_ch & reg_is(paddr, dri_pkg::OFF_HOLDING);
    assign irq_set = wr_ch & reg_is(paddr, dri_pkg::OFF_IRQ_SET) &
                     pstrb[0] & pwdata[dri_pkg::MASK_POS];
    assign irq_clr = wr_ch & reg_is(paddr, dri_pkg::OFF_IRQ_CLR) &
                     pstrb[0] & pwdata[dri_pkg::MASK_POS];

    // Mode register with byte lane merge.
    assign mode_wide = lane_merge({27'h000_0000, mode_r[g]}, pwdata, pstrb);
    assign mode_nxt = soft_rst ? dri_pkg::MODE_RST :
                      wr_mode ? mode_wide[dri_pkg::MODE_W-1:0] :
                      mode_r[g];

    assign trg_en = mode_r[g][dri_pkg::TRIG_EN_POS];
    assign trg_sel = mode_r[g][dri_pkg::TRIG_SEL_MSB:dri_pkg::TRIG_SEL_LSB];
    assign trg_turn_on = mode_nxt[dri_pkg::TRIG_EN_POS] & ~trg_en;

    // Reserved select codes match no timer wave and so never fire.
    assign trg_fire = trg_en &
                      (trg_sel < 3'(dri_pkg::NUM_TRG)) &
                      trg_rise_pad[trg_sel];

    // Holding register: the written word is right-aligned; 8-bit mode
    // moves it up by two so the output code keeps full-scale weight.
    assign hold_wide = lane_merge(32'h0000_0000, pwdata, pstrb);
    assign hold_nxt = soft_rst ? dri_pkg::DATA_RST :
                      !wr_hold ? hold_r[g] :
                      mode_r[g][dri_pkg::RES_POS] ?
                        {hold_wide[7:0], 2'b00} :
                        hold_wide[9:0];

    // Untriggered writes mark a copy that lands one clock later.
    assign copy_pend_nxt = wr_hold & ~trg_en & ~soft_rst;
    assign out_nxt = soft_rst ? dri_pkg::DATA_RST :
                     copy_pend_r[g] ? hold_r[g] :
                     trg_fire ? hold_r[g] :
                     out_r[g];

    // A write in the same cycle as a trigger edge keeps the flag low,
    // because the word just written has not yet reached the output.
    assign ready_nxt = soft_rst ? dri_pkg::READY_RST :
                       !mode_nxt[dri_pkg::TRIG_EN_POS] ? 1'b0 :
                       trg_turn_on ? 1'b1 :
                       wr_hold ? 1'b0 :
                       trg_fire ? 1'b1 :
                       ready_r[g];

    assign mask_nxt = soft_rst ? dri_pkg::MASK_RST :
                      irq_set ? 1'b1 :
                      irq_clr ? 1'b0 :
                      mask_r[g];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_r[g] <= dri_pkg::MODE_RST;
        hold_r[g] <= dri_pkg::DATA_RST;
        out_r[g] <= dri_pkg::DATA_RST;
        ready_r[g] <= dri_pkg::READY_RST;
        mask_r[g] <= dri_pkg::MASK_RST;
        copy_pend_r[g] <= 1'b0;
      end else begin
        mode_r[g] <= mode_nxt;
        hold_r[g] <= hold_nxt;
        out_r[g] <= out_nxt;
        ready_r[g] <= ready_nxt;
        mask_r[g] <= mask_nxt;
        copy_pend_r[g] <= copy_pend_nxt;
      end
    end

    // Read view; write-only registers read as zero.
    assign rd_val[g] =
      reg_is(paddr, dri_pkg::OFF_MODE) ? {27'h000_0000, mode_r[g]} :
      reg_is(paddr, dri_pkg::OFF_HOLDING) ?
        {22'h00_0000, hold_r[g]} :
      reg_is(paddr, dri_pkg::OFF_OUTPUT) ?
        {22'h00_0000, out_r[g]} :
      reg_is(paddr, dri_pkg::OFF_STATUS) ?
        {31'h0000_0000, ready_r[g]} :
      reg_is(paddr, dri_pkg::OFF_IRQ_MASK) ?
        {31'h0000_0000, mask_r[g]} :
      dri_pkg::RDATA_RST;

    assign conv_irq[g] = ready_r[g] & mask_r[g];
    assign dma_halfword[g] = ~mode_r[g][dri_pkg::RES_POS];
  end

  assign conv_code_0 = out_r[0];
  assign conv_code_1 = out_r[1];

  // ----------------------------------------------------------------------
  // Read data and error capture
  // ----------------------------------------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic slverr_r;
  logic slverr_nxt;
  logic [31:0] rd_sel;

  assign rd_sel = sel_ch1 ? rd_val[1] : rd_val[0];

  // Read data is captured in the setup cycle, so it is one clock older
  // than the access edge; a trigger edge in that clock is seen next read.
  assign prdata_nxt = !setup_ph ? prdata_r :
                      (!pwrite && any_hit) ? rd_sel :
                      dri_pkg::RDATA_RST;
  assign slverr_nxt = setup_ph ? ~any_hit : slverr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= dri_pkg::RDATA_RST;
      slverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = slverr_r & psel & penable;

endmodule

/* rtl/dri_pkg.sv */
// Package: constants for the converter register interface.
package dri_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry and instance placement
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int NUM_TRG = 6;
  localparam int DATA_W = 10;
  localparam int WIN_LSB = 14;
  localparam logic [31:0] BASE_CH0 = 32'hFFFA_8000;
  localparam logic [31:0] BASE_CH1 = 32'hFFFA_C000;

  // ----------------------------------------------------------------------
  // Register offsets within one instance window
  // ----------------------------------------------------------------------
  localparam logic [13:0] OFF_CONTROL = 14'h0000;
  localparam logic [13:0] OFF_MODE = 14'h0004;
  localparam logic [13:0] OFF_HOLDING = 14'h0008;
  localparam logic [13:0] OFF_OUTPUT = 14'h000C;
  localparam logic [13:0] OFF_STATUS = 14'h0010;
  localparam logic [13:0] OFF_IRQ_SET = 14'h0014;
  localparam logic [13:0] OFF_IRQ_CLR = 14'h0018;
  localparam logic [13:0] OFF_IRQ_MASK = 14'h001C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SOFT_RESET_POS = 0;
  localparam int TRIG_EN_POS = 0;
  localparam int TRIG_SEL_LSB = 1;
  localparam int TRIG_SEL_MSB = 3;
  localparam int RES_POS = 4;
  localparam int MODE_W = 5;
  localparam int READY_POS = 0;
  localparam int MASK_POS = 0;
  localparam int RES8_SHIFT = 2;

  // ----------------------------------------------------------------------
  // Values after reset and cycle counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [9:0] DATA_RST = 10'h000;
  localparam logic READY_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam int COPY_DELAY_CYC = 1;
  localparam int SYNC_STAGES = 3;

endpackage

/* rtl/dri_edge_sync.sv */
// Synchroniser and rising edge detector for one timer waveform input.
module dri_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wave_in,
  output logic rise_pulse
);

  // ----------------------------------------------------------------------
  // Three stage capture
  // ----------------------------------------------------------------------
  logic [dri_pkg::SYNC_STAGES-1:0] sync_r;
  logic level_r;
  logic level_nxt;

  // The first stage feeds only the second; a change is accepted once the
  // second and third stages agree, which filters a one-cycle glitch.
  assign level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= '0;
      level_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], wave_in};
      level_r <= level_nxt;
    end
  end

  assign rise_pulse = level_nxt & ~level_r;

endmodule

/* bench/dri_properties.sv */
// Port-level properties of the converter register interface, channel 0.
module dri_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] timer_wave_out,
  input wire logic [9:0] conv_code_0,
  input wire logic [9:0] conv_code_1,
  input wire logic [1:0] conv_irq,
  input wire logic [1:0] dma_halfword
);
  // ------------------------------------------------------------------
  // Shadow of mode and mask, kept from observed bus writes.
  // ------------------------------------------------------------------
  logic [1:0] md_r;
  logic msk_r;
  logic [3:0] qcnt_r;
  wire acc = psel && penable && pwrite && pready;
  wire in0 = paddr[31:14] == dri_pkg::BASE_CH0[31:14];
  wire in1 = paddr[31:14] == dri_pkg::BASE_CH1[31:14];
  wire w0 = acc && in0 && pstrb[0];
  wire wr_ctl = w0 && paddr[13:0] == dri_pkg::OFF_CONTROL && pwdata[0];
  wire wr_mode = w0 && paddr[13:0] == dri_pkg::OFF_MODE;
  wire wr_hold = w0 && paddr[13:0] == dri_pkg::OFF_HOLDING;
  wire wr_set = w0 && paddr[13:0] == dri_pkg::OFF_IRQ_SET && pwdata[0];
  wire wr_clr = w0 && paddr[13:0] == dri_pkg::OFF_IRQ_CLR && pwdata[0];
  wire [9:0] exp0 = md_r[1] ? {pwdata[7:0], 2'b00} : pwdata[9:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) md_r <= 2'b00;
    else if (wr_ctl) md_r <= 2'b00;
    else if (wr_mode) md_r <= {pwdata[4], pwdata[0]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msk_r <= 1'b0;
    else if (wr_ctl || wr_clr) msk_r <= 1'b0;
    else if (wr_set) msk_r <= 1'b1;
  end
  // A quiet timer line guarantees no copy is still in the synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) qcnt_r <= 4'h0;
    else if ($changed(timer_wave_out)) qcnt_r <= 4'h0;
    else if (qcnt_r != 4'hF) qcnt_r <= qcnt_r + 4'h1;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------------
  // Properties.
  // ------------------------------------------------------------------
  a_err_only_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_err_outside: assert property (
    psel && penable && !in0 && !in1 |-> pslverr)
    else $error("no error for address outside both windows");
  a_copy_next_cycle: assert property (
    wr_hold && !md_r[0] |=> $stable(conv_code_0) ##1
    conv_code_0 == $past(exp0, 2))
    else $error("output not loaded one cycle after holding write");
  a_hold_no_copy: assert property (
    wr_hold && md_r[0] && qcnt_r > 4'h8 |=> $stable(conv_code_0)[*2])
    else $error("holding write copied while timer trigger enabled");
  a_irq_off_idle: assert property (
    !md_r[0] && !$past(md_r[0]) |-> !conv_irq[0])
    else $error("interrupt while timer trigger disabled");
  a_irq_on_enable: assert property (
    $rose(md_r[0]) && msk_r |-> conv_irq[0])
    else $error("enabling trigger did not raise masked interrupt");
  a_irq_mask_clear: assert property (wr_clr |=> !conv_irq[0])
    else $error("interrupt stayed after mask clear");
  a_dma_size_res: assert property (dma_halfword[0] == !md_r[1])
    else $error("transfer size does not follow resolution");
  a_soft_reset_zero: assert property (
    wr_ctl |=> conv_code_0 == 10'h000 && !conv_irq[0] && dma_halfword[0])
    else $error("software reset did not clear state");
  cover property (wr_hold && md_r[0]);
  cover property ($rose(conv_irq[0]));
  cover property (pslverr);
endmodule

bind dri_top dri_properties u_dri_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_wave_out(timer_wave_out),
  .conv_code_0(conv_code_0), .conv_code_1(conv_code_1),
  .conv_irq(conv_irq), .dma_halfword(dma_halfword));

/* bench/tb.sv */
// Self-checking testbench of the converter register interface.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] timer_wave_out = 6'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] conv_code_0;
  logic [9:0] conv_code_1;
  logic [1:0] conv_irq;
  logic [1:0] dma_halfword;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic er;
  logic [9:0] cod [2] = '{10'h000, 10'h000};
  always #12.5 pclk = ~pclk;
  dri_top u_dri_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_wave_out(timer_wave_out), .conv_code_0(conv_code_0),
    .conv_code_1(conv_code_1), .conv_irq(conv_irq),
    .dma_halfword(dma_halfword));
  // ------------------------------------------------------------------
  // Bus tasks and checks.
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog may end a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ba(input int c, input logic [13:0] o);
    return (c == 1 ? dri_pkg::BASE_CH1 : dri_pkg::BASE_CH0) + {18'h0, o};
  endfunction
  task automatic wr(input int c, input logic [13:0] o, input logic [31:0] d);
    apb(1'b1, ba(c, o), d);
  endtask
  task automatic rchk(input int c, input logic [13:0] o, input logic [31:0] e);
    apb(1'b0, ba(c, o), 32'h0000_0000);
    chk(rd, e);
    chk({31'h0, er}, 32'h0000_0000);
  endtask
  // Eight-bit mode keeps the low byte and leaves the two low bits clear.
  function automatic logic [9:0] stored(input logic [31:0] v, input logic r8);
    return r8 ? {v[7:0], 2'b00} : v[9:0];
  endfunction
  function automatic logic [31:0] code_of(input int c);
    return {22'h0, c == 1 ? conv_code_1 : conv_code_0};
  endfunction
  task automatic end_of_test;
    $display("Checks: %0d, errors: %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    num_errors++;
    end_of_test();
  end
  // ------------------------------------------------------------------
  // Test sequence.
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [5:0] w;
    logic r8;
    int c;
    void'($urandom(12074));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      rchk(k / 8, 14'(4 * (k % 8)), 32'h0);
    end
    apb(1'b0, ba(0, 14'h0020), 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 32'h0000_1000, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    wr(1, dri_pkg::OFF_OUTPUT, 32'h0000_03FF);
    rchk(1, dri_pkg::OFF_OUTPUT, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      c = i % 2;
      // The first four passes pin both resolutions on both channels.
      r8 = (i < 4) ? 1'(i / 2) : 1'($urandom);
      v = (i > 9) ? 32'hFFFF_FFFF : $urandom;
      wr(c, dri_pkg::OFF_MODE, {27'h0, r8, 4'h0});
      wr(c, dri_pkg::OFF_HOLDING, v);
      @(negedge pclk);
      chk(code_of(c), {22'h0, cod[c]});
      cod[c] = stored(v, r8);
      @(negedge pclk);
      chk(code_of(c), {22'h0, cod[c]});
      chk({31'h0, dma_halfword[c]}, {31'h0, !r8});
      rchk(c, dri_pkg::OFF_HOLDING, {22'h0, cod[c]});
      rchk(c, dri_pkg::OFF_STATUS, 32'h0000_0000);
    end
    for (int s = 0; s < 8; s++) begin
      c = s % 2;
      wr(c, dri_pkg::OFF_MODE, {28'h0, 3'(s), 1'b1});
      rchk(c, dri_pkg::OFF_STATUS, 32'h0000_0001);
      v = $urandom;
      wr(c, dri_pkg::OFF_HOLDING, v);
      rchk(c, dri_pkg::OFF_STATUS, 32'h0000_0000);
      rchk(c, dri_pkg::OFF_OUTPUT, {22'h0, cod[c]});
      w = (s < 6) ? 6'h01 << s : 6'h3F;
      @(posedge pclk);
      timer_wave_out <= w;
      repeat (5) @(posedge pclk);
      timer_wave_out <= 6'h00;
      repeat (10) @(posedge pclk);
      if (s < 6) cod[c] = v[9:0];
      rchk(c, dri_pkg::OFF_OUTPUT, {22'h0, cod[c]});
      rchk(c, dri_pkg::OFF_STATUS, {31'h0, s < 6});
    end
    wr(0, dri_pkg::OFF_MODE, 32'h0000_0000);
    wr(0, dri_pkg::OFF_IRQ_SET, 32'h0000_0000);
    rchk(0, dri_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    wr(0, dri_pkg::OFF_IRQ_SET, 32'h0000_0001);
    rchk(0, dri_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    chk({31'h0, conv_irq[0]}, 32'h0000_0000);
    wr(0, dri_pkg::OFF_MODE, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, conv_irq[0]}, 32'h0000_0001);
    wr(0, dri_pkg::OFF_HOLDING, 32'h0000_0005);
    @(negedge pclk);
    chk({31'h0, conv_irq[0]}, 32'h0000_0000);
    // Re-arm the flag so that clearing the mask has a live request to hide.
    wr(0, dri_pkg::OFF_MODE, 32'h0000_0000);
    wr(0, dri_pkg::OFF_MODE, 32'h0000_0001);
    wr(0, dri_pkg::OFF_IRQ_CLR, 32'h0000_0000);
    rchk(0, dri_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    chk({31'h0, conv_irq[0]}, 32'h0000_0001);
    wr(0, dri_pkg::OFF_IRQ_CLR, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, conv_irq[0]}, 32'h0000_0000);
    rchk(0, dri_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    wr(0, dri_pkg::OFF_IRQ_SET, 32'h0000_0001);
    wr(0, dri_pkg::OFF_MODE, 32'h0000_0011);
    wr(0, dri_pkg::OFF_CONTROL, 32'h0000_0000);
    rchk(0, dri_pkg::OFF_MODE, 32'h0000_0011);
    wr(0, dri_pkg::OFF_CONTROL, 32'h0000_0001);
    for (int k = 1; k < 8; k++) rchk(0, 14'(4 * k), 32'h0);
    rchk(1, dri_pkg::OFF_MODE, 32'h0000_000F);
    end_of_test();
  end
endmodule
